// ===== axis_pkg.sv
// constants, register map and carrier types for the axis pulse block
// assumes a single 40 MHz controller clock and a plain register port
package axis_pkg;

    // ****************************************************************
    // sizes
    // ****************************************************************
    localparam int NUM_AXES   = 5;
    localparam int NUM_ALM    = 6;
    localparam int DATA_W     = 16;
    localparam int ADDR_W     = 8;
    localparam int ACC_W      = 32;
    localparam int TMR_W      = 19;
    localparam int RAMP_STEPS = 3;

    // ****************************************************************
    // register offsets (word index on the plain port)
    // ****************************************************************
    localparam logic [ADDR_W-1:0] OFS_GEAR_MUL  = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_GEAR_DIV  = 8'h05;
    localparam logic [ADDR_W-1:0] OFS_BL_AMT    = 8'h0a;
    localparam logic [ADDR_W-1:0] OFS_BL_RATE   = 8'h0f;
    localparam logic [ADDR_W-1:0] OFS_BL_MODE   = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_DIR_INV   = 8'h15;
    localparam logic [ADDR_W-1:0] OFS_ALM_POL   = 8'h16;
    localparam logic [ADDR_W-1:0] OFS_ALM_MASK  = 8'h17;
    localparam logic [ADDR_W-1:0] OFS_ALM_STAT  = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_BL_BUSY   = 8'h19;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int BIT_WAIT     = 0;
    localparam int BIT_RAMP     = 1;
    localparam int DIR_INV_LSB  = 1;
    localparam int ALM_SPINDLE  = 5;
    localparam int BIT_SPINDLE_ALARM_IGNORE     = 4;
    localparam int BIT_FEED_ALARM_IGNORE     = 7;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [DATA_W-1:0] RST_GEAR    = 16'h0001;
    localparam logic [DATA_W-1:0] RST_BL_AMT  = 16'h0000;
    localparam logic [DATA_W-1:0] RST_BL_RATE = 16'h0001;
    localparam logic [7:0]        RST_BITS    = 8'h00;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

    typedef enum {BL_IDLE, BL_ISSUE} bl_state_t;

endpackage

// ===== axis_pulse_gear_backlash_alarm.sv
// pulse gear, backlash insertion, direction inversion and drive alarms
// assumes cmd_pulse/cmd_dir and drv_alarm_in are synchronous to mclk
// Behaviour
// - scale every axis's commanded pulses by its programmable gear ratio
// - five multipliers, five divisors; output count equals input times mul over div
// - on reversal, insert the axis's backlash amount as extra pulses
// - per-axis rate setting paces the backlash pulses
// - wait bit set: hold next block until backlash pulses finish
// - ramp bit set: accelerate/decelerate backlash pulses; clear: fixed rate
// - direction bit set inverts that axis's direction output
// - alarm raised when drive alarm input equals its polarity bit
// - raised alarm stays latched until operator reset
// - spindle mask bit set ignores spindle alarm input
// - feed mask bit set ignores all feed axis alarm inputs
`timescale 1ns/1ps
module axis_pulse_gear_backlash_alarm
    import axis_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  arst_n,
    input  wire reg_req_t              req,
    output logic [DATA_W-1:0]          rdata,
    input  wire logic [NUM_AXES-1:0]   cmd_pulse,
    input  wire logic [NUM_AXES-1:0]   cmd_dir,
    output logic [NUM_AXES-1:0]        drv_pulse,
    output logic [NUM_AXES-1:0]        drv_dir,
    input  wire logic [NUM_ALM-1:0]    drv_alarm_in,
    input  wire logic                  operator_reset,
    output logic [NUM_ALM-1:0]         alarm_out,
    output logic                       alarm_any,
    output logic                       block_hold
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic in_bank(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] base);
        in_bank = (a >= base) && (a < base + 8'(NUM_AXES));
    endfunction

    // slow start and slow finish, never below one cycle
    function automatic logic [TMR_W-1:0] bl_period(input logic [DATA_W-1:0] rate,
                                                   input logic              ramp,
                                                   input logic [DATA_W-1:0] done,
                                                   input logic [DATA_W-1:0] left);
        logic [DATA_W-1:0] r;
        logic [DATA_W-1:0] edge_dist;
        logic [2:0]        f;
        r         = (rate == 16'h0000) ? 16'h0001 : rate;
        edge_dist = (done < left - 16'h0001) ? done : left - 16'h0001;
        if (!ramp) begin
            f = 3'h1;
        end else if (edge_dist >= 16'(RAMP_STEPS)) begin
            f = 3'h1;
        end else begin
            f = 3'(RAMP_STEPS + 1) - edge_dist[2:0];
        end
        bl_period = TMR_W'(r) * TMR_W'(f);
    endfunction

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [DATA_W-1:0] gear_mul_r [NUM_AXES];
    logic [DATA_W-1:0] gear_div_r [NUM_AXES];
    logic [DATA_W-1:0] bl_amt_r   [NUM_AXES];
    logic [DATA_W-1:0] bl_rate_r  [NUM_AXES];
    logic [7:0]        bl_mode_r;
    logic [7:0]        dir_inv_r;
    logic [7:0]        alm_pol_r;
    logic [7:0]        alm_mask_r;
    logic [NUM_ALM-1:0] alarm_r;

    logic [ACC_W-1:0]  acc_r      [NUM_AXES];
    bl_state_t         bl_st_r    [NUM_AXES];
    logic [DATA_W-1:0] bl_left_r  [NUM_AXES];
    logic [DATA_W-1:0] bl_done_r  [NUM_AXES];
    logic [TMR_W-1:0]  bl_tmr_r   [NUM_AXES];
    logic [NUM_AXES-1:0] last_dir_r;
    logic [NUM_AXES-1:0] bl_dir_r;

    logic [NUM_AXES-1:0] gear_ready;
    logic [NUM_AXES-1:0] gear_fire;
    logic [NUM_AXES-1:0] rev_bl;
    logic [NUM_AXES-1:0] bl_fire;
    logic [NUM_AXES-1:0] bl_busy;
    logic [NUM_ALM-1:0]  alm_raw;
    logic [DATA_W-1:0]   rdata_nxt;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NUM_AXES; i++) begin
                gear_mul_r[i] <= RST_GEAR;
                gear_div_r[i] <= RST_GEAR;
                bl_amt_r[i]   <= RST_BL_AMT;
                bl_rate_r[i]  <= RST_BL_RATE;
            end
            bl_mode_r  <= RST_BITS;
            dir_inv_r  <= RST_BITS;
            alm_pol_r  <= RST_BITS;
            alm_mask_r <= RST_BITS;
        end else if (req.wr) begin
            if (in_bank(req.addr, OFS_GEAR_MUL)) begin
                gear_mul_r[3'(req.addr - OFS_GEAR_MUL)] <= req.wdata;
            end
            if (in_bank(req.addr, OFS_GEAR_DIV)) begin
                gear_div_r[3'(req.addr - OFS_GEAR_DIV)] <= req.wdata;
            end
            if (in_bank(req.addr, OFS_BL_AMT)) begin
                bl_amt_r[3'(req.addr - OFS_BL_AMT)] <= req.wdata;
            end
            if (in_bank(req.addr, OFS_BL_RATE)) begin
                bl_rate_r[3'(req.addr - OFS_BL_RATE)] <= req.wdata;
            end
            if (req.addr == OFS_BL_MODE) begin
                bl_mode_r <= req.wdata[7:0];
            end
            if (req.addr == OFS_DIR_INV) begin
                dir_inv_r <= req.wdata[7:0];
            end
            if (req.addr == OFS_ALM_POL) begin
                alm_pol_r <= req.wdata[7:0];
            end
            if (req.addr == OFS_ALM_MASK) begin
                alm_mask_r <= req.wdata[7:0];
            end
        end
    end

    // ****************************************************************
    // read port
    // ****************************************************************
    always_comb begin
        rdata_nxt = '0;
        if (in_bank(req.addr, OFS_GEAR_MUL)) begin
            rdata_nxt = gear_mul_r[3'(req.addr - OFS_GEAR_MUL)];
        end else if (in_bank(req.addr, OFS_GEAR_DIV)) begin
            rdata_nxt = gear_div_r[3'(req.addr - OFS_GEAR_DIV)];
        end else if (in_bank(req.addr, OFS_BL_AMT)) begin
            rdata_nxt = bl_amt_r[3'(req.addr - OFS_BL_AMT)];
        end else if (in_bank(req.addr, OFS_BL_RATE)) begin
            rdata_nxt = bl_rate_r[3'(req.addr - OFS_BL_RATE)];
        end else if (req.addr == OFS_BL_MODE) begin
            rdata_nxt = {8'h00, bl_mode_r};
        end else if (req.addr == OFS_DIR_INV) begin
            rdata_nxt = {8'h00, dir_inv_r};
        end else if (req.addr == OFS_ALM_POL) begin
            rdata_nxt = {8'h00, alm_pol_r};
        end else if (req.addr == OFS_ALM_MASK) begin
            rdata_nxt = {8'h00, alm_mask_r};
        end else if (req.addr == OFS_ALM_STAT) begin
            rdata_nxt = {10'h000, alarm_r};
        end else if (req.addr == OFS_BL_BUSY) begin
            rdata_nxt = {11'h000, bl_busy};
        end
    end

    // read data live one cycle only
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= '0;
        end else begin
            rdata <= req.rd ? rdata_nxt : '0;
        end
    end

    // ****************************************************************
    // per-axis decisions
    // ****************************************************************
    always_comb begin
        for (int i = 0; i < NUM_AXES; i++) begin
            // credit available for one output pulse
            gear_ready[i] = (gear_div_r[i] != 16'h0000) &&
                            (acc_r[i] >= ACC_W'(gear_div_r[i]));
            bl_busy[i]    = (bl_st_r[i] == BL_ISSUE);
            rev_bl[i]     = gear_ready[i] && !bl_busy[i] &&
                            (cmd_dir[i] != last_dir_r[i]) &&
                            (bl_amt_r[i] != 16'h0000);
            gear_fire[i]  = gear_ready[i] && !bl_busy[i] && !rev_bl[i];
            bl_fire[i]    = bl_busy[i] && (bl_tmr_r[i] == '0);
        end
    end

    // ****************************************************************
    // gear accumulator
    // ****************************************************************
    // one output per cycle; ratios above one queue credit in the accumulator
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NUM_AXES; i++) begin
                acc_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_AXES; i++) begin
                acc_r[i] <= acc_r[i]
                          + (cmd_pulse[i] ? ACC_W'(gear_mul_r[i]) : '0)
                          - (gear_fire[i] ? ACC_W'(gear_div_r[i]) : '0);
            end
        end
    end

    // ****************************************************************
    // backlash sequencer
    // ****************************************************************
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NUM_AXES; i++) begin
                bl_st_r[i]   <= BL_IDLE;
                bl_left_r[i] <= '0;
                bl_done_r[i] <= '0;
                bl_tmr_r[i]  <= '0;
            end
            last_dir_r <= '0;
            bl_dir_r   <= '0;
        end else begin
            for (int i = 0; i < NUM_AXES; i++) begin
                if (gear_fire[i]) begin
                    last_dir_r[i] <= cmd_dir[i];
                end
                unique case (bl_st_r[i])
                    BL_IDLE: begin
                        if (rev_bl[i]) begin
                            bl_st_r[i]    <= BL_ISSUE;
                            bl_left_r[i]  <= bl_amt_r[i];
                            bl_done_r[i]  <= '0;
                            bl_dir_r[i]   <= cmd_dir[i];
                            last_dir_r[i] <= cmd_dir[i];
                            // first spacing from ramp or fixed rate
                            bl_tmr_r[i]   <= bl_period(bl_rate_r[i], bl_mode_r[BIT_RAMP],
                                                       16'h0000, bl_amt_r[i]) - TMR_W'(1);
                        end
                    end
                    BL_ISSUE: begin
                        if (bl_fire[i]) begin
                            bl_left_r[i] <= bl_left_r[i] - 16'h0001;
                            bl_done_r[i] <= bl_done_r[i] + 16'h0001;
                            if (bl_left_r[i] == 16'h0001) begin
                                bl_st_r[i] <= BL_IDLE;
                            end
                            // rate register paces the next pulse
                            bl_tmr_r[i] <= bl_period(bl_rate_r[i], bl_mode_r[BIT_RAMP],
                                                     bl_done_r[i] + 16'h0001,
                                                     bl_left_r[i] - 16'h0001) - TMR_W'(1);
                        end else begin
                            bl_tmr_r[i] <= bl_tmr_r[i] - TMR_W'(1);
                        end
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // drive outputs
    // ****************************************************************
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            drv_pulse <= '0;
            drv_dir   <= '0;
        end else begin
            for (int i = 0; i < NUM_AXES; i++) begin
                drv_pulse[i] <= gear_fire[i] | bl_fire[i];
                if (bl_fire[i]) begin
                    drv_dir[i] <= bl_dir_r[i] ^ dir_inv_r[DIR_INV_LSB + i];
                end else if (gear_fire[i]) begin
                    drv_dir[i] <= cmd_dir[i] ^ dir_inv_r[DIR_INV_LSB + i];
                end
            end
        end
    end

    assign block_hold = bl_mode_r[BIT_WAIT] && (|bl_busy);

    // ****************************************************************
    // drive alarms
    // ****************************************************************
    always_comb begin
        for (int i = 0; i < NUM_ALM; i++) begin
            alm_raw[i] = (drv_alarm_in[i] == alm_pol_r[i]);
        end
        if (alm_mask_r[BIT_FEED_ALARM_IGNORE]) begin
            alm_raw[NUM_AXES-1:0] = '0;
        end
        if (alm_mask_r[BIT_SPINDLE_ALARM_IGNORE]) begin
            alm_raw[ALM_SPINDLE] = 1'b0;
        end
    end

    // a live alarm during operator reset stays set
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            alarm_r <= '0;
        end else begin
            alarm_r <= (alarm_r & ~{NUM_ALM{operator_reset}}) | alm_raw;
        end
    end

    assign alarm_out = alarm_r;
    assign alarm_any = |alarm_r;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    AST_GEAR_OUT: assert property (gear_fire[0] |=> drv_pulse[0])
        else $error("gear credit did not produce a pulse");
    AST_GEAR_DIV0: assert property ((gear_div_r[1] == 16'h0000) |-> !gear_fire[1])
        else $error("pulse with zero divisor");
    AST_GEAR_REM: assert property ((gear_fire[0] && !cmd_pulse[0]) |=>
        (acc_r[0] == $past(acc_r[0]) - ACC_W'($past(gear_div_r[0]))))
        else $error("remainder not carried");
    AST_BL_LOAD: assert property (rev_bl[2] |=>
        (bl_busy[2] && bl_left_r[2] == $past(bl_amt_r[2])))
        else $error("backlash amount not loaded on reversal");
    AST_BL_STALL: assert property (bl_busy[2] |-> !gear_fire[2])
        else $error("gear pulse during backlash");
    AST_BL_FIXED: assert property ((bl_fire[2] && !bl_mode_r[BIT_RAMP] &&
        bl_left_r[2] > 16'h0001 && bl_rate_r[2] > 16'h0000) |=>
        (bl_tmr_r[2] == TMR_W'($past(bl_rate_r[2])) - TMR_W'(1)))
        else $error("fixed rate spacing wrong");
    // first spacing is four periods for any amount, since nothing is done yet
    AST_BL_RAMP: assert property ((rev_bl[3] && bl_mode_r[BIT_RAMP] &&
        bl_amt_r[3] > 16'h0000 && bl_rate_r[3] > 16'h0000) |=>
        (bl_tmr_r[3] == TMR_W'($past(bl_rate_r[3])) * TMR_W'(4) - TMR_W'(1)))
        else $error("ramp does not start slow");
    AST_HOLD: assert property (bl_busy[2] && bl_mode_r[BIT_WAIT] |-> block_hold)
        else $error("block not held during backlash");
    AST_DIR: assert property (gear_fire[4] |=>
        (drv_dir[4] == ($past(cmd_dir[4]) ^ $past(dir_inv_r[DIR_INV_LSB + 4]))))
        else $error("direction inversion wrong");
    AST_ALM_SET: assert property (alm_raw[ALM_SPINDLE] |=> alarm_r[ALM_SPINDLE])
        else $error("alarm not raised");
    AST_ALM_HOLD: assert property ((alarm_r[0] && !operator_reset) |=> alarm_r[0])
        else $error("alarm dropped without reset");
    AST_FEED_MASK: assert property (alm_mask_r[BIT_FEED_ALARM_IGNORE] |-> (alm_raw[NUM_AXES-1:0] == '0))
        else $error("feed alarm not masked");
    AST_SPIN_MASK: assert property (alm_mask_r[BIT_SPINDLE_ALARM_IGNORE] |-> !alm_raw[ALM_SPINDLE])
        else $error("spindle alarm not masked");

    COV_REVERSAL: cover property (rev_bl[2] ##1 bl_busy[2] [*3]);
    COV_HOLD:     cover property (block_hold ##[1:50] !block_hold);
    COV_ALARM:    cover property (alarm_r[ALM_SPINDLE] ##1 operator_reset);
    COV_RAMP:     cover property (bl_fire[3] && bl_mode_r[BIT_RAMP]);

endmodule // axis_pulse_gear_backlash_alarm

// ===== drive_unit_model.sv
// behavioural drive units: count pulses, keep direction, return alarm level
// assumes drive pulses are synchronous to mclk; alarm level set by the bench
`timescale 1ns/1ps
module drive_unit_model
    import axis_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                arst_n,
    input  wire logic [NUM_AXES-1:0] drv_pulse,
    input  wire logic [NUM_AXES-1:0] drv_dir,
    input  wire logic [NUM_ALM-1:0]  alarm_level,
    output logic [NUM_ALM-1:0]       drv_alarm_in,
    output logic [15:0]              cnt [NUM_AXES],
    output logic [NUM_AXES-1:0]      last_dir
);
    // ****************************************************************
    // drive side
    // ****************************************************************
    // alarm line level as commanded
    assign drv_alarm_in = alarm_level;

    // pulses kept as a plain up count, direction ignored: no loss check inside the drive
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NUM_AXES; i++) begin
                cnt[i] <= 16'h0000;
            end
            last_dir <= '0;
        end else begin
            for (int i = 0; i < NUM_AXES; i++) begin
                if (drv_pulse[i]) begin
                    cnt[i]      <= cnt[i] + 16'h0001;
                    last_dir[i] <= drv_dir[i];
                end
            end
        end
    end
endmodule // drive_unit_model

// ===== tb.sv
// self-checking bench for the axis pulse block and its drive units
// assumes axis_pkg and drive_unit_model are compiled first
`timescale 1ns/1ps
module tb
    import axis_pkg::*;
;
    logic                mclk;
    logic                arst_n;
    reg_req_t            req;
    logic [DATA_W-1:0]   rdata;
    logic [NUM_AXES-1:0] cmd_pulse;
    logic [NUM_AXES-1:0] cmd_dir;
    logic [NUM_AXES-1:0] drv_pulse;
    logic [NUM_AXES-1:0] drv_dir;
    logic [NUM_ALM-1:0]  drv_alarm_in;
    logic [NUM_ALM-1:0]  alarm_level;
    logic                operator_reset;
    logic [NUM_ALM-1:0]  alarm_out;
    logic                alarm_any;
    logic                block_hold;
    logic [15:0]         cnt [NUM_AXES];
    logic [NUM_AXES-1:0] last_dir;
    int                  errors;
    int                  tests_run;
    int                  cyc;
    int                  n;

    axis_pulse_gear_backlash_alarm dut (.mclk(mclk), .arst_n(arst_n), .req(req),
        .rdata(rdata), .cmd_pulse(cmd_pulse), .cmd_dir(cmd_dir), .drv_pulse(drv_pulse),
        .drv_dir(drv_dir), .drv_alarm_in(drv_alarm_in), .operator_reset(operator_reset),
        .alarm_out(alarm_out), .alarm_any(alarm_any), .block_hold(block_hold));
    drive_unit_model drives (.mclk(mclk), .arst_n(arst_n), .drv_pulse(drv_pulse),
        .drv_dir(drv_dir), .alarm_level(alarm_level), .drv_alarm_in(drv_alarm_in),
        .cnt(cnt), .last_dir(last_dir));

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge mclk);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        req <= '0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge mclk);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        req <= '0;
        #1 chk(rdata, exp);
    endtask
    task automatic pls(input int a, input logic dir, input int gap);
        @(posedge mclk);
        cmd_dir[a]   <= dir;
        cmd_pulse[a] <= 1'b1;
        @(posedge mclk);
        cmd_pulse[a] <= 1'b0;
        repeat (gap) @(posedge mclk);
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task automatic nxt(input int a, output int k);
        k = 0;
        do begin
            @(posedge mclk);
            #1 k++;
        end while (drv_pulse[a] !== 1'b1 && k < 200);
    endtask
    task automatic set_alm(input logic [NUM_ALM-1:0] v);
        @(posedge mclk);
        alarm_level <= v;
    endtask
    task automatic ores();
        @(posedge mclk);
        operator_reset <= 1'b1;
        @(posedge mclk);
        operator_reset <= 1'b0;
    endtask
    task automatic summarize();
        $display("tests_run=%0d errors=%0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ****************************************************************
    // clock, reset, timeout, tests
    // ****************************************************************
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // whole run needs about 240 cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        arst_n         = 1'b0;
        req            = '0;
        cmd_pulse      = '0;
        cmd_dir        = '0;
        operator_reset = 1'b0;
        // polarity bits all 0: healthy drive holds its alarm line high
        alarm_level    = 6'h3f;
        errors         = 0;
        tests_run      = 0;
        cyc            = 0;
        repeat (10) @(posedge mclk);
        arst_n <= 1'b1;
        rc(OFS_GEAR_MUL, RST_GEAR);
        rc(OFS_GEAR_DIV + 8'h04, RST_GEAR);
        rc(OFS_BL_AMT, RST_BL_AMT);
        rc(OFS_BL_RATE, RST_BL_RATE);
        rc(OFS_BL_MODE, {8'h00, RST_BITS});
        wr(8'h30, 16'h5a5a);
        wr(OFS_ALM_STAT, 16'h00ff);
        rc(8'h30, 16'h0000);
        rc(OFS_ALM_STAT, 16'h0000);
        $display("test registers done");
        wr(OFS_GEAR_MUL, 16'h0005);
        wr(OFS_GEAR_DIV, 16'h0004);
        rc(OFS_GEAR_DIV, 16'h0004);
        repeat (8) pls(0, 1'b0, 3);
        idle(4);
        chk(cnt[0], 16'h000a);
        repeat (3) pls(0, 1'b0, 3);
        idle(4);
        chk(cnt[0], 16'h000d);
        wr(OFS_GEAR_DIV + 8'h01, 16'h0000);
        repeat (2) pls(1, 1'b0, 3);
        idle(4);
        chk(cnt[1], 16'h0000);
        $display("test gear done");
        wr(OFS_DIR_INV, 16'h0020);
        rc(OFS_DIR_INV, 16'h0020);
        pls(4, 1'b0, 3);
        idle(2);
        chk({15'h0000, drv_dir[4]}, 16'h0001);
        $display("test direction done");
        // remaining axes left at unity gear
        wr(OFS_BL_AMT + 8'h02, 16'h0002);
        wr(OFS_BL_RATE + 8'h02, 16'h0003);
        wr(OFS_BL_MODE, 16'h0001);
        pls(2, 1'b0, 3);
        idle(3);
        chk(cnt[2], 16'h0001);
        pls(2, 1'b1, 0);
        idle(1);
        chk({15'h0000, block_hold}, 16'h0001);
        nxt(2, n);
        nxt(2, n);
        chk(n[15:0], 16'h0003);
        idle(10);
        chk(cnt[2], 16'h0004);
        chk({15'h0000, last_dir[2]}, 16'h0001);
        chk({15'h0000, block_hold}, 16'h0000);
        wr(OFS_BL_AMT + 8'h03, 16'h0002);
        wr(OFS_BL_RATE + 8'h03, 16'h0002);
        wr(OFS_BL_MODE, 16'h0002);
        pls(3, 1'b0, 3);
        pls(3, 1'b1, 0);
        idle(1);
        chk({15'h0000, block_hold}, 16'h0000);
        rc(OFS_BL_BUSY, 16'h0008);
        nxt(3, n);
        nxt(3, n);
        chk({15'h0000, n > 2}, 16'h0001);
        // ramp: both pulses sit at the slow edge, four periods of two cycles
        chk(n[15:0], 16'h0008);
        idle(10);
        chk(cnt[3], 16'h0004);
        rc(OFS_BL_BUSY, 16'h0000);
        $display("test backlash done");
        set_alm(6'h3e);
        idle(3);
        chk({10'h000, alarm_out}, 16'h0001);
        chk({15'h0000, alarm_any}, 16'h0001);
        set_alm(6'h3f);
        wr(OFS_ALM_POL, 16'h0002);
        idle(3);
        chk({10'h000, alarm_out}, 16'h0003);
        set_alm(6'h3d);
        ores();
        idle(2);
        chk({10'h000, alarm_out}, 16'h0000);
        wr(OFS_ALM_MASK, 16'h0090);
        rc(OFS_ALM_MASK, 16'h0090);
        set_alm(6'h1f);
        ores();
        idle(3);
        chk({10'h000, alarm_out}, 16'h0000);
        wr(OFS_ALM_MASK, 16'h0080);
        idle(3);
        chk({10'h000, alarm_out}, 16'h0020);
        wr(OFS_ALM_MASK, 16'h0000);
        idle(3);
        chk({10'h000, alarm_out}, 16'h0022);
        rc(OFS_ALM_STAT, 16'h0022);
        ores();
        idle(1);
        chk({10'h000, alarm_out}, 16'h0022);
        $display("test alarms done");
        summarize();
    end
endmodule // tb
